// ==== inc/pgpm_pkg.sv ====
// shared constants for the power-ok and phase mode supervisor
package pgpm_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned PWROK_DELAY_US = 5000;
    localparam int unsigned SLEW_HOLD_US = 20;
    localparam int unsigned PWROK_DELAY_CYC = (PWROK_DELAY_US * (CLK_HZ / 1_000_000));
    localparam int unsigned SLEW_HOLD_CYC = (SLEW_HOLD_US * (CLK_HZ / 1_000_000));
    localparam int unsigned SLOW_SLEW_DIV = 8;
    localparam logic [1:0] MODE_SKIP = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h1;
    typedef enum logic [2:0] {
        PGPM_OFF = 3'h0,
        PGPM_START = 3'h1,
        PGPM_BOOT = 3'h3,
        PGPM_TOVID = 3'h2,
        PGPM_RUN = 3'h6,
        PGPM_SOFTOFF = 3'h4
    } pgpm_state_e;
endpackage

// ==== hw/pgpm_ctrl.sv ====
// power-ok sequencing, phase and mode selection, thermal alarm
// What this block does
// - power-ok low until 5ms after clock-gate drops
// - then release power-ok only inside window
// - power-ok low in soft-shutdown and shutdown
// - power-ok released during slew plus 20us
// - skip downward slew ignores upper threshold
// - mode inputs select phase count and skip
// - deep-sleep low: power-state picks one/two phase
// - startup two-phase skip, soft-off two-phase PWM
// - boot skip, boot-to-code transition forced PWM
// - phase two disabled means phase one only
// - alarm when thermistor below limit, off released
// - rails-ok low at startup holds boot voltage
// - rails-ok fall: gate request, slow slew boot
`timescale 1ns/1ps
module pgpm_ctrl #(
    parameter int unsigned PWROK_DELAY = pgpm_pkg::PWROK_DELAY_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_enable,
    input wire logic i_softstart_done,
    input wire logic i_softoff_done,
    input wire logic i_slew_active,
    input wire logic i_slew_down,
    input wire logic i_system_rails_ok,
    input wire logic i_deep_sleep_request,
    input wire logic i_power_state_hint,
    input wire logic i_phase_two_sense_pos,
    input wire logic i_fb_above_low,
    input wire logic i_fb_below_high,
    input wire logic i_thermistor_below_limit,
    output logic o_power_ok_out_oe_n,
    output logic o_overtemp_alarm_n_oe_n,
    output logic o_clock_gate_request_n,
    output logic o_phase_two_on,
    output logic o_forced_pwm,
    output logic o_target_boot,
    output logic o_slow_slew,
    output logic o_converter_on
);
    // every pin-side input passes two flops; stage one is read only by stage two
    localparam int NIN = 12;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    assign raw = {i_enable, i_softstart_done, i_softoff_done, i_slew_active, i_slew_down, i_system_rails_ok,
                  i_deep_sleep_request, i_power_state_hint, i_phase_two_sense_pos, i_fb_above_low,
                  i_fb_below_high, i_thermistor_below_limit};
    genvar g;
    generate
        for (g = 0; g < NIN; g++) begin : g_sync
            always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= raw[g];
                    s2_q[g] <= s1_q[g];
                end
            end
        end
    endgenerate
    wire en = s2_q[11];
    wire ss_done = s2_q[10];
    wire off_done = s2_q[9];
    wire slewing = s2_q[8];
    wire slew_dn = s2_q[7];
    wire rails_ok = s2_q[6];
    wire dslp = s2_q[5];
    wire psi_hi = s2_q[4];
    wire ph2_dis = s2_q[3];
    wire fb_lo_ok = s2_q[2];
    wire fb_hi_ok = s2_q[1];
    wire hot = s2_q[0];

    pgpm_pkg::pgpm_state_e st_q, st_d;
    logic [22:0] dly_q;
    logic [9:0] hold_q;
    logic blank_hi_q;
    logic slew_prev_q;
    logic pok_q, hot_q, gate_q, ph2_q, pwm_q, boot_q, slow_q, on_q;

    always_comb begin
        st_d = st_q;
        case (st_q)
            pgpm_pkg::PGPM_OFF: if (en) st_d = pgpm_pkg::PGPM_START;
            pgpm_pkg::PGPM_START: if (ss_done) st_d = pgpm_pkg::PGPM_BOOT;
            pgpm_pkg::PGPM_BOOT: if (rails_ok) st_d = pgpm_pkg::PGPM_TOVID;
            pgpm_pkg::PGPM_TOVID: if (slew_prev_q && !slewing) st_d = pgpm_pkg::PGPM_RUN;
            pgpm_pkg::PGPM_RUN: if (!rails_ok) st_d = pgpm_pkg::PGPM_BOOT;
            pgpm_pkg::PGPM_SOFTOFF: if (off_done) st_d = pgpm_pkg::PGPM_OFF;
            default: st_d = pgpm_pkg::PGPM_OFF;
        endcase
        if (!en && st_q != pgpm_pkg::PGPM_OFF && st_q != pgpm_pkg::PGPM_SOFTOFF) begin
            st_d = pgpm_pkg::PGPM_SOFTOFF;
        end
    end

    wire in_run = (st_q == pgpm_pkg::PGPM_RUN);
    wire in_boot = (st_q == pgpm_pkg::PGPM_BOOT);
    wire in_start = (st_q == pgpm_pkg::PGPM_START);
    wire in_tovid = (st_q == pgpm_pkg::PGPM_TOVID);
    wire in_soff = (st_q == pgpm_pkg::PGPM_SOFTOFF);
    wire in_off = (st_q == pgpm_pkg::PGPM_OFF);
    // a rails loss raises the gate request in the same cycle that the state leaves run
    wire gate_d = in_off || in_start || in_boot || in_soff || (in_run && !rails_ok);
    wire dly_done = (dly_q == 23'(PWROK_DELAY));
    wire slew_end = slew_prev_q && !slewing;
    // downward skip slews mask the upper threshold until the hold expires and fb is back below the upper threshold
    wire blank_d = (slewing && slew_dn && !pwm_q) ? 1'b1 : (blank_hi_q && !(hold_q == 10'h0 && fb_hi_ok));
    wire win_ok = fb_lo_ok && (fb_hi_ok || blank_hi_q);
    wire slew_force = slewing || (hold_q != 10'h0);
    wire pok_d = in_run && rails_ok && dly_done && (slew_force || win_ok);
    // mode table: deep sleep forces skip, power-state picks phase count
    wire mode_skip = dslp;
    wire mode_two = !dslp && psi_hi;
    wire pwm_d = in_soff || in_tovid || (in_run && !mode_skip);
    wire two_d = !ph2_dis && (in_start || in_boot || in_tovid || in_soff || (in_run && mode_two));
    // slow slew holds only while parked at boot after a rails loss
    wire slow_d = (in_run && !rails_ok) || (in_boot && slow_q && st_d == pgpm_pkg::PGPM_BOOT);

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= pgpm_pkg::PGPM_OFF;
            dly_q <= 23'h0;
            hold_q <= 10'h0;
            blank_hi_q <= 1'b0;
            slew_prev_q <= 1'b0;
        end else begin
            st_q <= st_d;
            slew_prev_q <= slewing;
            blank_hi_q <= blank_d;
            // delay runs from the gate request drop, so the boot-to-code slew counts toward it
            if (gate_q) dly_q <= 23'h0;
            else if (!dly_done) dly_q <= dly_q + 23'h1;
            if (slewing) hold_q <= 10'(pgpm_pkg::SLEW_HOLD_CYC);
            else if (hold_q != 10'h0) hold_q <= hold_q - 10'h1;
        end
    end

    // registered pins; open-drain enables low while pulling
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pok_q <= 1'b0;
            hot_q <= 1'b1;
            gate_q <= 1'b1;
            ph2_q <= 1'b0;
            pwm_q <= 1'b0;
            boot_q <= 1'b1;
            slow_q <= 1'b0;
            on_q <= 1'b0;
        end else begin
            pok_q <= pok_d;
            hot_q <= ~(hot && !in_off);
            gate_q <= gate_d;
            ph2_q <= two_d;
            pwm_q <= pwm_d;
            boot_q <= !(in_tovid || in_run);
            slow_q <= slow_d;
            on_q <= !in_off;
        end
    end
    assign o_power_ok_out_oe_n = pok_q;
    assign o_overtemp_alarm_n_oe_n = hot_q;
    assign o_clock_gate_request_n = gate_q;
    assign o_phase_two_on = ph2_q;
    assign o_forced_pwm = pwm_q;
    assign o_target_boot = boot_q;
    assign o_slow_slew = slow_q;
    assign o_converter_on = on_q;

    AST_POK_LOW_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_off || in_soff) |=> !o_power_ok_out_oe_n)
        else $error("power ok released in shutdown");
    AST_POK_DELAY: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (!dly_done) |=> !o_power_ok_out_oe_n)
        else $error("power ok released before delay");
    AST_SLEW_REL: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_run && dly_done && slewing && st_d == st_q) |=> o_power_ok_out_oe_n)
        else $error("power ok not released in slew");
    AST_HOLD_LOAD: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $fell(slewing) |-> hold_q == 10'(pgpm_pkg::SLEW_HOLD_CYC))
        else $error("slew hold not loaded");
    AST_WINDOW: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_run && dly_done && !slew_force && !fb_lo_ok) |=> !o_power_ok_out_oe_n)
        else $error("power ok out of window");
    AST_SOFTOFF_PWM: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_soff || in_tovid) |=> o_forced_pwm)
        else $error("soft off or transition not pwm");
    AST_START_SKIP: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_start || in_boot) |=> !o_forced_pwm)
        else $error("startup not skip");
    AST_PH2_DIS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        ph2_dis |=> !o_phase_two_on)
        else $error("phase two on while disabled");
    AST_SKIP_SEL: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_run && dslp) |=> (!o_forced_pwm && !o_phase_two_on))
        else $error("deep sleep not one phase skip");
    AST_HOT_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        in_off |=> o_overtemp_alarm_n_oe_n)
        else $error("alarm pulled in shutdown");
    AST_RAILS_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_run && !rails_ok) |=> ##1 o_clock_gate_request_n)
        else $error("gate request not raised");
    AST_MODE_TWO: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_run && !dslp && psi_hi && !ph2_dis) |=> (o_forced_pwm && o_phase_two_on))
        else $error("full power not two phase pwm");
    AST_MODE_ONE_PWM: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_run && !dslp && !psi_hi) |=> (o_forced_pwm && !o_phase_two_on))
        else $error("low power state not one phase pwm");
    AST_BOOT_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_boot && !rails_ok) |=> (o_clock_gate_request_n && !o_power_ok_out_oe_n && o_target_boot))
        else $error("boot hold not kept while rails low");
    AST_HOT_PULL: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (hot && !in_off) |=> !o_overtemp_alarm_n_oe_n)
        else $error("alarm not pulled when hot");
    AST_BLANK_UPPER: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_run && st_d == st_q && dly_done && fb_lo_ok && blank_hi_q) |=> o_power_ok_out_oe_n)
        else $error("upper threshold not blanked");
    AST_SLOW_SET: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (in_run && !rails_ok) |=> o_slow_slew)
        else $error("slow slew not requested on rails loss");
    COV_BLANK: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) in_run && blank_hi_q && !fb_hi_ok);
    COV_RUN: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) in_run && !o_power_ok_out_oe_n);
    COV_SLEW: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) $fell(slewing) && in_run);
    COV_RAILS: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) in_run && !rails_ok);
    COV_SOFTOFF: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) in_soff && off_done);
endmodule

// ==== tb/pgpm_platform.sv ====
// platform side model: soft-start and soft-shutdown completion
`timescale 1ns/1ps
module pgpm_platform (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_enable,
    input wire logic i_converter_on,
    output logic o_softstart_done,
    output logic o_softoff_done
);
    logic [7:0] ss_q;
    logic [7:0] so_q;
    // ramps take eight cycles; real ramps are longer, only the order matters here
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ss_q <= 8'h00;
            so_q <= 8'h00;
        end else begin
            ss_q <= {ss_q[6:0], i_converter_on};
            so_q <= {so_q[6:0], i_converter_on & ~i_enable};
        end
    end
    assign o_softstart_done = ss_q[7];
    assign o_softoff_done = so_q[7];
endmodule

// ==== tb/pgpm_ctrl_bench.sv ====
// self-checking bench for the power-ok and phase mode supervisor
`timescale 1ns/1ps
module pgpm_ctrl_bench;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, slew = 1'b0, sdn = 1'b0, rails = 1'b0;
    logic ds = 1'b0, power_state_hint = 1'b1, strap = 1'b0, fl = 1'b1, fh = 1'b1, thr = 1'b1;
    logic pok, hot, gate, ph2, pwm, boot, slow, on, ss, so;
    int err_total = 0, n_checks = 0;
    initial forever #20 clk = ~clk;
    pgpm_platform u_pgpm_platform (.i_sys_clk(clk), .i_arst_n(rst_n), .i_enable(en), .i_converter_on(on),
        .o_softstart_done(ss), .o_softoff_done(so));
    // short power-ok delay keeps the run brief
    pgpm_ctrl #(.PWROK_DELAY(50)) u_pgpm_ctrl (.i_sys_clk(clk), .i_arst_n(rst_n), .i_enable(en),
        .i_softstart_done(ss), .i_softoff_done(so), .i_slew_active(slew), .i_slew_down(sdn),
        .i_system_rails_ok(rails), .i_deep_sleep_request(ds), .i_power_state_hint(power_state_hint),
        .i_phase_two_sense_pos(strap), .i_fb_above_low(fl), .i_fb_below_high(fh),
        .i_thermistor_below_limit(thr), .o_power_ok_out_oe_n(pok), .o_overtemp_alarm_n_oe_n(hot),
        .o_clock_gate_request_n(gate), .o_phase_two_on(ph2), .o_forced_pwm(pwm), .o_target_boot(boot),
        .o_slow_slew(slow), .o_converter_on(on));
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %0t: got %b expected %b", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_reset;
        wt(16);
        chk(pok, 1'b0);
        chk(hot, 1'b1);
        @(posedge clk) rst_n <= 1'b1;
        wt(4);
    endtask
    task automatic t_start;
        @(posedge clk) en <= 1'b1;
        wt(6);
        chk(ph2, 1'b1);
        chk(pwm, 1'b0);
        wt(200);
        chk(ph2, 1'b1);
        chk(pwm, 1'b0);
        chk(gate, 1'b1);
        chk(pok, 1'b0);
        chk(hot, 1'b0);
    endtask
    task automatic t_tovid;
        @(posedge clk) rails <= 1'b1;
        wt(6);
        chk(pwm, 1'b1);
        chk(gate, 1'b0);
        chk(pok, 1'b0);
        @(posedge clk) slew <= 1'b1;
        fl <= 1'b0;
        wt(6);
        chk(pok, 1'b0);
        @(posedge clk) slew <= 1'b0;
        wt(400);
        chk(pok, 1'b1);
        wt(120);
        chk(pok, 1'b0);
        @(posedge clk) fl <= 1'b1;
        wt(6);
        chk(pok, 1'b1);
    endtask
    task automatic t_modes(input logic s);
        @(posedge clk) strap <= s;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) {ds, power_state_hint} <= 2'(i);
            wt(6);
            chk(ph2, i == 1 && !s);
            chk(pwm, i < 2);
        end
        @(posedge clk) {ds, power_state_hint, strap} <= 3'h2;
    endtask
    task automatic t_blank;
        @(posedge clk) {ds, fh, sdn, slew} <= 4'hb;
        wt(6);
        chk(pok, 1'b1);
        @(posedge clk) slew <= 1'b0;
        wt(540);
        chk(pok, 1'b1);
        @(posedge clk) fh <= 1'b1;
        wt(6);
        @(posedge clk) fh <= 1'b0;
        wt(6);
        chk(pok, 1'b0);
        @(posedge clk) {ds, fh, sdn, thr} <= 4'h4;
        wt(6);
        chk(hot, 1'b1);
    endtask
    task automatic t_loss_off;
        @(posedge clk) rails <= 1'b0;
        wt(6);
        chk(gate, 1'b1);
        chk(pok, 1'b0);
        chk(slow, 1'b1);
        chk(boot, 1'b1);
        chk(pwm, 1'b0);
        chk(ph2, 1'b1);
        @(posedge clk) en <= 1'b0;
        thr <= 1'b1;
        wt(5);
        chk(pwm, 1'b1);
        chk(pok, 1'b0);
        wt(30);
        chk(on, 1'b0);
        chk(pok, 1'b0);
        chk(hot, 1'b1);
    endtask
    initial begin
        t_reset();
        t_start();
        t_tovid();
        t_modes(1'b0);
        t_modes(1'b1);
        t_blank();
        t_loss_off();
        test_done();
    end
    // the sequence needs about 1440 cycles
    initial begin
        wt(20000);
        err_total++;
        test_done();
    end
endmodule
